// ===== inc/ttcu_pkg.sv
// Constants shared by the three-timer counter unit and its pin edge helper
package ttcu_pkg;

  // Register indices on the plain register port
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFS_MODE = 4'h0;
  localparam logic [3:0] OFS_CTRL = 4'h1;
  localparam logic [3:0] OFS_T2CTRL = 4'h2;
  localparam logic [3:0] OFS_T2MODE = 4'h3;
  localparam logic [3:0] OFS_TL0 = 4'h4;
  localparam logic [3:0] OFS_TH0 = 4'h5;
  localparam logic [3:0] OFS_TL1 = 4'h6;
  localparam logic [3:0] OFS_TH1 = 4'h7;
  localparam logic [3:0] OFS_TL2 = 4'h8;
  localparam logic [3:0] OFS_TH2 = 4'h9;
  localparam logic [3:0] OFS_RCAPL = 4'ha;
  localparam logic [3:0] OFS_RCAPH = 4'hb;
  localparam logic [3:0] OFS_MISC = 4'hc;

  // Mode select register: one nibble each for timers 0 and 1
  localparam int T0_NIB = 0;
  localparam int T1_NIB = 4;
  localparam int NIB_CNT = 2;
  localparam int NIB_GATE = 3;

  // Control register bits
  localparam int RUN0 = 0;
  localparam int RUN1 = 1;
  localparam int FLAG0 = 4;
  localparam int FLAG1 = 5;

  // Third timer control and mode bits
  localparam int T2_FLAG = 7;
  localparam int T2_EXFLAG = 6;
  localparam int T2_RXCLK = 5;
  localparam int T2_TXCLK = 4;
  localparam int T2_EXEN = 3;
  localparam int T2_RUN = 2;
  localparam int T2_CNT = 1;
  localparam int T2_CAPT = 0;
  localparam int T2_OUT_EN = 1;

  // Misc register bits
  localparam int CLK_DBL = 0;
  localparam int GPIO_LAT = 1;
  localparam int GPIO_OE = 2;
  localparam int MISC_W = 3;

  // Reset values and fill patterns
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [MISC_W-1:0] RST_MISC = 3'h0;
  localparam logic [7:0] BYTE_ONES = 8'hff;
  localparam logic [15:0] WORD_ONES = 16'hffff;

  // Timer 0/1 modes
  localparam logic [1:0] MODE_13BIT = 2'h0;
  localparam logic [1:0] MODE_16BIT = 2'h1;
  localparam logic [1:0] MODE_RELOAD8 = 2'h2;
  localparam logic [1:0] MODE_SPLIT = 2'h3;

  // Core clocks per machine cycle
  localparam logic [3:0] MC_CLKS_STD = 4'hc;
  localparam logic [3:0] MC_CLKS_DBL = 4'h6;

  // External pin indices
  localparam int PIN_T0 = 0;
  localparam int PIN_T1 = 1;
  localparam int PIN_G0 = 2;
  localparam int PIN_G1 = 3;
  localparam int PIN_CAPTURE_RELOAD_TRIGGER_PIN = 4;
  localparam int PIN_T2 = 5;
  localparam int PIN_N = 6;
  localparam logic PIN_IDLE = 1'b0;

endpackage

// ===== inc/ttcu_pin_if.sv
// Pin levels and their detected falling edges between core and edge helper
`timescale 1ns/1ps
`default_nettype none
interface ttcu_pin_if;
  import ttcu_pkg::*;
  logic [PIN_N-1:0] level;
  logic [PIN_N-1:0] fall;
  modport edge_side (input level, output fall);
  modport core_side (output level, input fall);
endinterface
`default_nettype wire

// ===== verilog/ttcu_pin_edge.sv
// Falling-edge detection on the external count, gate and trigger pins
`timescale 1ns/1ps
`default_nettype none
module ttcu_pin_edge (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Pin levels in, edges out
  ttcu_pin_if.edge_side pins
);
  import ttcu_pkg::*;

  logic [PIN_N-1:0] prev_q;

  // One previous-level flop per pin; reset low so no edge fires at release
  for (genvar i = 0; i < PIN_N; i++) begin : g_pin
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        prev_q[i] <= PIN_IDLE;
      end else begin
        prev_q[i] <= pins.level[i];
      end
    end
    assign pins.fall[i] = prev_q[i] & ~pins.level[i];
  end

endmodule
`default_nettype wire

// ===== verilog/ttcu_top.sv
// Three 16-bit timer/counters with auto-reload, capture, baud and clock-out
//
// Notes on behaviour
// - Three independent 16-bit timer/counters, each usable as interval timer or counter.
// - Each count is read and written as a high byte and a low byte.
// - First timer nibble: modes 0-3, plus 4 for counter, plus 8 for gating.
// - First timer runs on its run bit, or gate-pin falling edges when gated.
// - Second timer nibble: modes 0-3, 40H counter, 80H adds gating.
// - Second timer runs on its run bit, or gate-pin falling edges when gated.
// - Third timer control value selects reload, capture, baud and counter modes.
// - Internally controlled third timer reloads only on overflow and never captures.
// - External trigger falling edge also captures/reloads, except in baud mode.
// - A 50% duty clock can be driven onto the shared port pin.
// - The same pin can serve as the third timer count input.
// - Clock-out frequency is core clock over n times (65536 minus reload).
// - Factor n is 4 in 12-clock mode, 2 in 6-clock mode.
// - Third timer overflows raise no flag in clock-out or baud mode.
// - Baud generation and clock-out may run together from one timer.
`timescale 1ns/1ps
`default_nettype none
module ttcu_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Register port
  input wire logic [ttcu_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  // External pins
  input wire logic t0_count_pin,
  input wire logic t1_count_pin,
  input wire logic gate_pin_zero,
  input wire logic gate_pin_one,
  input wire logic capture_reload_trigger_pin,
  // Shared port pin: clock out or count in
  input wire logic port_pin_in,
  output logic port_pin_out_q,
  output logic port_pin_oe_q,
  // Overflow and trigger flags and baud tick
  output logic timer_zero_flag_q,
  output logic timer_one_flag_q,
  output logic timer_two_flag_q,
  output logic timer_two_ext_flag_q,
  output logic baud_tick_q
);
  import ttcu_pkg::*;

  logic [7:0] timer_mode_select_reg;
  logic [1:0] run_q;
  logic [1:0] hw_on_q;
  logic [7:0] third_timer_control_reg;
  logic third_timer_mode_reg;
  logic [MISC_W-1:0] misc_q;
  logic [7:0] tl0_q, th0_q, tl1_q, th1_q, tl2_q, th2_q;
  logic [15:0] rcap_q;
  logic [3:0] pre_q;
  logic half_q;
  logic [1:0] gate_en, gate_fall;
  logic [1:0] m0, m1;
  logic cnt0, cnt1, mc_tick, fast_tick, mc_last_hit;
  logic [3:0] mc_last;
  logic run0, run1, inc0, inc0_hi, inc1, ovf0, ovf1;
  logic [16:0] step0, step1;
  logic t2_baud, t2_clkout, t2_reload, t2_fast, inc2, ov2, ext_evt;
  logic [15:0] cnt2, nxt2;
  logic [7:0] ctrl_view, rd_mux;

  ttcu_pin_if pins ();

  ttcu_pin_edge u_edge (
    .mclk(mclk),
    .arst_n(arst_n),
    .pins(pins.edge_side)
  );

  assign pins.level[PIN_T0] = t0_count_pin;
  assign pins.level[PIN_T1] = t1_count_pin;
  assign pins.level[PIN_G0] = gate_pin_zero;
  assign pins.level[PIN_G1] = gate_pin_one;
  assign pins.level[PIN_CAPTURE_RELOAD_TRIGGER_PIN] = capture_reload_trigger_pin;
  assign pins.level[PIN_T2] = port_pin_in;

  // Register write decode, shared by every register process
  function automatic logic ttcu_hit(input logic stb, input logic [3:0] a, input logic [3:0] o);
    return stb && (a == o);
  endfunction

  // One count step of timer 0/1: {overflow, high, low}
  function automatic logic [16:0] ttcu_step(input logic [1:0] md, input logic [7:0] hi,
                                            input logic [7:0] lo);
    logic [16:0] r;
    logic [13:0] c13;
    logic [8:0] c8;
    c13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    c8 = {1'b0, lo} + 9'h001;
    case (md)
      MODE_13BIT: r = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
      MODE_16BIT: r = {1'b0, hi, lo} + 17'h00001;
      MODE_RELOAD8: r = c8[8] ? {1'b1, hi, hi} : {1'b0, hi, c8[7:0]};
      default: r = {c8[8], hi, c8[7:0]};
    endcase
    return r;
  endfunction

  // Mode decode of the shared mode register
  assign m0 = timer_mode_select_reg[T0_NIB +: 2];
  assign cnt0 = timer_mode_select_reg[T0_NIB + NIB_CNT];
  assign m1 = timer_mode_select_reg[T1_NIB +: 2];
  assign cnt1 = timer_mode_select_reg[T1_NIB + NIB_CNT];
  assign gate_en[0] = timer_mode_select_reg[T0_NIB + NIB_GATE];
  assign gate_en[1] = timer_mode_select_reg[T1_NIB + NIB_GATE];
  assign gate_fall[0] = pins.fall[PIN_G0];
  assign gate_fall[1] = pins.fall[PIN_G1];

  // Machine-cycle prescaler; 6-clock mode halves the period
  assign mc_last = misc_q[CLK_DBL] ? MC_CLKS_DBL - 4'h1 : MC_CLKS_STD - 4'h1;
  assign mc_last_hit = (pre_q >= mc_last);
  assign mc_tick = (pre_q == mc_last);
  assign fast_tick = misc_q[CLK_DBL] ? 1'b1 : half_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pre_q <= 4'h0;
      half_q <= 1'b0;
    end else begin
      pre_q <= mc_last_hit ? 4'h0 : pre_q + 4'h1;
      half_q <= ~half_q;
    end
  end

  // Hardware gate latches: each gate-pin fall toggles run while the run bit is set
  for (genvar g = 0; g < 2; g++) begin : g_gate
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        hw_on_q[g] <= 1'b0;
      end else if (!run_q[g]) begin
        hw_on_q[g] <= 1'b0;
      end else if (gate_fall[g]) begin
        hw_on_q[g] <= ~hw_on_q[g];
      end
    end
  end

  // Run and increment enables for timers 0 and 1
  assign run0 = run_q[0] & (~gate_en[0] | hw_on_q[0]);
  assign run1 = run_q[1] & (~gate_en[1] | hw_on_q[1]) & (m1 != MODE_SPLIT);
  assign inc0 = run0 & (cnt0 ? pins.fall[PIN_T0] : mc_tick);
  assign inc1 = run1 & (cnt1 ? pins.fall[PIN_T1] : mc_tick);
  // Split high byte is a plain timer borrowing timer 1's run bit
  assign inc0_hi = (m0 == MODE_SPLIT) & run_q[1] & mc_tick;
  assign step0 = ttcu_step(m0, th0_q, tl0_q);
  assign step1 = ttcu_step(m1, th1_q, tl1_q);
  assign ovf0 = inc0 & step0[16];
  assign ovf1 = (m0 == MODE_SPLIT) ? (inc0_hi & (th0_q == BYTE_ONES)) : (inc1 & step1[16]);

  // Timer 0 count bytes; a software write beats a count in the same cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tl0_q <= RST_BYTE;
      th0_q <= RST_BYTE;
    end else begin
      if (ttcu_hit(reg_wr, reg_addr, OFS_TL0)) begin
        tl0_q <= reg_wdata;
      end else if (inc0) begin
        tl0_q <= step0[7:0];
      end
      if (ttcu_hit(reg_wr, reg_addr, OFS_TH0)) begin
        th0_q <= reg_wdata;
      end else if (m0 == MODE_SPLIT) begin
        if (inc0_hi) begin
          th0_q <= th0_q + 8'h01;
        end
      end else if (inc0) begin
        th0_q <= step0[15:8];
      end
    end
  end

  // Timer 1 count bytes
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tl1_q <= RST_BYTE;
      th1_q <= RST_BYTE;
    end else begin
      if (ttcu_hit(reg_wr, reg_addr, OFS_TL1)) begin
        tl1_q <= reg_wdata;
      end else if (inc1) begin
        tl1_q <= step1[7:0];
      end
      if (ttcu_hit(reg_wr, reg_addr, OFS_TH1)) begin
        th1_q <= reg_wdata;
      end else if (inc1) begin
        th1_q <= step1[15:8];
      end
    end
  end

  // Third timer mode decode
  assign t2_baud = third_timer_control_reg[T2_RXCLK] | third_timer_control_reg[T2_TXCLK];
  assign t2_clkout = third_timer_mode_reg & ~third_timer_control_reg[T2_CNT];
  // Baud and clock-out both force reload from the capture pair
  assign t2_reload = ~third_timer_control_reg[T2_CAPT] | t2_baud | t2_clkout;
  assign t2_fast = t2_baud | t2_clkout;
  // Nothing starts until software sets the run bit itself
  assign inc2 = third_timer_control_reg[T2_RUN] & (t2_fast ? fast_tick :
                (third_timer_control_reg[T2_CNT] ? pins.fall[PIN_T2] : mc_tick));
  assign cnt2 = {th2_q, tl2_q};
  assign ov2 = inc2 & (cnt2 == WORD_ONES);
  assign ext_evt = third_timer_control_reg[T2_EXEN] & pins.fall[PIN_CAPTURE_RELOAD_TRIGGER_PIN] & ~t2_baud;

  // Next count: overflow or trigger reloads in reload mode, otherwise count up
  always_comb begin
    nxt2 = cnt2;
    if ((ov2 || ext_evt) && t2_reload) begin
      nxt2 = rcap_q;
    end else if (inc2) begin
      nxt2 = cnt2 + 16'h0001;
    end
  end

  // Timer 2 bytes and capture pair
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      tl2_q <= RST_BYTE;
      th2_q <= RST_BYTE;
      rcap_q <= {RST_BYTE, RST_BYTE};
    end else begin
      tl2_q <= ttcu_hit(reg_wr, reg_addr, OFS_TL2) ? reg_wdata : nxt2[7:0];
      th2_q <= ttcu_hit(reg_wr, reg_addr, OFS_TH2) ? reg_wdata : nxt2[15:8];
      if (ttcu_hit(reg_wr, reg_addr, OFS_RCAPL)) begin
        rcap_q[7:0] <= reg_wdata;
      end else if (ext_evt && !t2_reload) begin
        rcap_q[7:0] <= tl2_q;
      end
      if (ttcu_hit(reg_wr, reg_addr, OFS_RCAPH)) begin
        rcap_q[15:8] <= reg_wdata;
      end else if (ext_evt && !t2_reload) begin
        rcap_q[15:8] <= th2_q;
      end
    end
  end

  // Configuration registers and sticky flags; a hardware set beats a clear
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      timer_mode_select_reg <= RST_BYTE;
      run_q <= 2'b00;
      third_timer_control_reg <= RST_BYTE;
      third_timer_mode_reg <= 1'b0;
      misc_q <= RST_MISC;
      timer_zero_flag_q <= 1'b0;
      timer_one_flag_q <= 1'b0;
      timer_two_flag_q <= 1'b0;
      timer_two_ext_flag_q <= 1'b0;
    end else begin
      if (ttcu_hit(reg_wr, reg_addr, OFS_MODE)) begin
        timer_mode_select_reg <= reg_wdata;
      end
      if (ttcu_hit(reg_wr, reg_addr, OFS_CTRL)) begin
        run_q <= {reg_wdata[RUN1], reg_wdata[RUN0]};
      end
      if (ttcu_hit(reg_wr, reg_addr, OFS_T2CTRL)) begin
        third_timer_control_reg <= reg_wdata;
      end
      if (ttcu_hit(reg_wr, reg_addr, OFS_T2MODE)) begin
        third_timer_mode_reg <= reg_wdata[T2_OUT_EN];
      end
      if (ttcu_hit(reg_wr, reg_addr, OFS_MISC)) begin
        misc_q <= reg_wdata[MISC_W-1:0];
      end
      timer_zero_flag_q <= ovf0 |
        (ttcu_hit(reg_wr, reg_addr, OFS_CTRL) ? reg_wdata[FLAG0] : timer_zero_flag_q);
      timer_one_flag_q <= ovf1 |
        (ttcu_hit(reg_wr, reg_addr, OFS_CTRL) ? reg_wdata[FLAG1] : timer_one_flag_q);
      timer_two_flag_q <= (ov2 & ~t2_fast) |
        (ttcu_hit(reg_wr, reg_addr, OFS_T2CTRL) ? reg_wdata[T2_FLAG] : timer_two_flag_q);
      timer_two_ext_flag_q <= ext_evt |
        (ttcu_hit(reg_wr, reg_addr, OFS_T2CTRL) ? reg_wdata[T2_EXFLAG] : timer_two_ext_flag_q);
    end
  end

  // Shared pin: toggling on each overflow gives a 50% duty clock at f/(n*(65536-reload))
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      port_pin_out_q <= 1'b0;
      port_pin_oe_q <= 1'b0;
      baud_tick_q <= 1'b0;
    end else begin
      port_pin_oe_q <= t2_clkout |
        (~third_timer_control_reg[T2_CNT] & misc_q[GPIO_OE]);
      if (t2_clkout) begin
        if (ov2) begin
          port_pin_out_q <= ~port_pin_out_q;
        end
      end else begin
        port_pin_out_q <= misc_q[GPIO_LAT];
      end
      baud_tick_q <= ov2 & t2_baud;
    end
  end

  // Read mux; data stand only in the cycle after the read strobe
  always_comb begin
    ctrl_view = RST_BYTE;
    ctrl_view[RUN0] = run_q[0];
    ctrl_view[RUN1] = run_q[1];
    ctrl_view[FLAG0] = timer_zero_flag_q;
    ctrl_view[FLAG1] = timer_one_flag_q;
    case (reg_addr)
      OFS_MODE: rd_mux = timer_mode_select_reg;
      OFS_CTRL: rd_mux = ctrl_view;
      OFS_T2CTRL: rd_mux = {timer_two_flag_q, timer_two_ext_flag_q,
                            third_timer_control_reg[T2_RXCLK:0]};
      OFS_T2MODE: rd_mux = {6'h00, third_timer_mode_reg, 1'b0};
      OFS_TL0: rd_mux = tl0_q;
      OFS_TH0: rd_mux = th0_q;
      OFS_TL1: rd_mux = tl1_q;
      OFS_TH1: rd_mux = th1_q;
      OFS_TL2: rd_mux = tl2_q;
      OFS_TH2: rd_mux = th2_q;
      OFS_RCAPL: rd_mux = rcap_q[7:0];
      OFS_RCAPH: rd_mux = rcap_q[15:8];
      OFS_MISC: rd_mux = {5'h00, misc_q};
      default: rd_mux = RST_BYTE;
    endcase
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_q <= RST_BYTE;
    end else begin
      reg_rdata_q <= reg_rd ? rd_mux : RST_BYTE;
    end
  end

  // Checks on the counting behaviour
  a_tl0_write_wins: assert property (
    @(posedge mclk) disable iff (!arst_n)
    ttcu_hit(reg_wr, reg_addr, OFS_TL0) |=> tl0_q == $past(reg_wdata))
    else $error("low byte write of timer 0 lost");

  a_t0_stopped_holds: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (!run_q[0] && !reg_wr) |=> $stable(tl0_q))
    else $error("timer 0 low byte moved while its run bit was clear");

  a_t1_split_frozen: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (m1 == MODE_SPLIT && !reg_wr) |=> ($stable(tl1_q) && $stable(th1_q)))
    else $error("timer 1 counted in mode 3");

  a_t1_gate_off: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (gate_en[1] && !hw_on_q[1] && !reg_wr) |=> $stable(tl1_q))
    else $error("gated timer 1 counted without a gate edge");

  a_t0_pin_count: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (m0 == MODE_16BIT && cnt0 && run0 && !reg_wr && pins.fall[PIN_T0])
      |=> {th0_q, tl0_q} == $past({th0_q, tl0_q}) + 16'h0001)
    else $error("counter use missed a falling edge");

  a_t0_13bit_wrap: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (m0 == MODE_13BIT && inc0 && th0_q == BYTE_ONES && tl0_q[4:0] == 5'h1f && !reg_wr)
      |=> (th0_q == RST_BYTE && tl0_q[4:0] == 5'h00 && timer_zero_flag_q))
    else $error("13-bit count did not wrap to zero with a flag");

  a_t2_ovf_reload: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (ov2 && t2_reload && !reg_wr) |=> {th2_q, tl2_q} == $past(rcap_q))
    else $error("overflow did not reload the third timer");

  a_t2_ext_capture: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (ext_evt && !t2_reload && !reg_wr) |=> rcap_q == $past(cnt2))
    else $error("trigger edge did not capture the count");

  a_t2_baud_noext: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (t2_baud && !timer_two_ext_flag_q && !reg_wr) |=> !timer_two_ext_flag_q)
    else $error("trigger pin acted during baud generation");

  a_t2_flag_quiet: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (t2_fast && !timer_two_flag_q && !reg_wr) |=> !timer_two_flag_q)
    else $error("overflow flag raised in baud or clock-out mode");

  a_clkout_pin_drive: assert property (
    @(posedge mclk) disable iff (!arst_n)
    t2_clkout ##1 t2_clkout |-> port_pin_oe_q && (port_pin_out_q != $past(port_pin_out_q)
      || !$past(ov2)))
    else $error("clock-out pin not driven or not toggled on overflow");

  a_count_pin_input: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (third_timer_control_reg[T2_CNT] && !t2_clkout) |=> !port_pin_oe_q)
    else $error("pin driven while used as count input");

  a_mc_tick_spacing: assert property (
    @(posedge mclk) disable iff (!arst_n)
    mc_tick |=> !mc_tick [*5])
    else $error("machine cycle shorter than six clocks");

endmodule
`default_nettype wire

// ===== sim/ttcu_pin_drv.sv
// Behavioural driver of the external count, gate and trigger pins
`timescale 1ns/1ps
`default_nettype none
module ttcu_pin_drv (
  // Clock
  input wire logic mclk,
  // Pin levels, idle high like pulled-up inputs
  output logic [5:0] pin_q
);
  initial pin_q = 6'h3f;

  // Low pulses, each level held two cycles so no edge is missed
  task automatic pulse(input int idx, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge mclk);
      pin_q[idx] <= 1'b0;
      repeat (2) @(posedge mclk);
      pin_q[idx] <= 1'b1;
      repeat (2) @(posedge mclk);
    end
  endtask
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// Self-checking bench for the three-timer counter unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import ttcu_pkg::*;
  localparam logic [15:0] RLD = 16'hfffc;
  logic mclk;
  logic arst_n;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata_q;
  logic t0_count_pin, t1_count_pin, gate_pin_zero, gate_pin_one;
  logic capture_reload_trigger_pin, port_pin_in, port_pin_out_q, port_pin_oe_q;
  logic timer_zero_flag_q, timer_one_flag_q, timer_two_flag_q;
  logic timer_two_ext_flag_q, baud_tick_q, baud_seen, baud_clr;
  logic [5:0] pin_q;
  int error_cnt = 0;
  int check_count = 0;
  int cyc = 0;
  int hp;

  // Pins from the driver; the shared pin is resolved from both sides
  assign {capture_reload_trigger_pin, gate_pin_one, gate_pin_zero} = pin_q[4:2];
  assign {t1_count_pin, t0_count_pin} = pin_q[1:0];
  assign port_pin_in = port_pin_oe_q ? port_pin_out_q : pin_q[5];

  ttcu_top i_dut (.mclk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
    .t0_count_pin, .t1_count_pin, .gate_pin_zero, .gate_pin_one,
    .capture_reload_trigger_pin, .port_pin_in, .port_pin_out_q, .port_pin_oe_q,
    .timer_zero_flag_q, .timer_one_flag_q, .timer_two_flag_q, .timer_two_ext_flag_q,
    .baud_tick_q);
  ttcu_pin_drv u_pins (.mclk, .pin_q);

  // Clock and cycle count; baud pulses are one cycle, so latch them
  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (baud_clr) baud_seen <= 1'b0;
    else if (baud_tick_q === 1'b1) baud_seen <= 1'b1;
  end

  task automatic results();
    if (error_cnt == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp, input logic [7:0] m);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata_q & m, exp);
  endtask

  // Cycles until the shared pin output changes, bounded
  task automatic wait_tog(output int n);
    logic p;
    p = port_pin_out_q;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (port_pin_out_q === p && n < 200);
  endtask

  // Hang guard
  initial begin
    wait (cyc == 20000);
    error_cnt++;
    results();
  end

  initial begin
    mclk = 1'b0;
    arst_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    baud_clr = 1'b1;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    baud_clr <= 1'b0;
    // All indices read zero after reset, unmapped ones stay zero
    for (int a = 0; a < 16; a++) rdc(4'(a), 8'h00, 8'hff);
    wr(4'hd, 8'hff);
    rdc(4'hd, 8'h00, 8'hff);
    wr(OFS_TL0, 8'haa);
    rdc(OFS_TL0, 8'haa, 8'hff);
    // 13-bit counter wraps from all ones; upper low-byte bits ignored
    wr(OFS_MODE, 8'h04);
    wr(OFS_TH0, 8'hff);
    wr(OFS_TL0, 8'h1f);
    wr(OFS_CTRL, 8'h01);
    u_pins.pulse(PIN_T0, 1);
    rdc(OFS_TL0, 8'h00, 8'h1f);
    rdc(OFS_TH0, 8'h00, 8'hff);
    chk({7'h0, timer_zero_flag_q}, 8'h01);
    wr(OFS_MODE, 8'h05);
    wr(OFS_CTRL, 8'h01);
    wr(OFS_TL0, 8'h00);
    u_pins.pulse(PIN_T0, 3);
    rdc(OFS_TL0, 8'h03, 8'hff);
    // 8-bit auto-reload counter: overflow reloads low byte from high byte
    wr(OFS_MODE, 8'h06);
    wr(OFS_TH0, 8'hfe);
    wr(OFS_TL0, 8'hff);
    u_pins.pulse(PIN_T0, 1);
    rdc(OFS_TL0, 8'hfe, 8'hff);
    rdc(OFS_CTRL, 8'h11, 8'hff);
    // Gated counters ignore counts until a gate falling edge
    for (int i = 0; i < 2; i++) begin
      wr(OFS_CTRL, 8'h00);
      wr(OFS_MODE, i ? 8'hd0 : 8'h0d);
      wr(OFS_TL0 + 4'(2 * i), 8'h00);
      wr(OFS_CTRL, 8'(1 << i));
      u_pins.pulse(PIN_T0 + i, 2);
      rdc(OFS_TL0 + 4'(2 * i), 8'h00, 8'hff);
      u_pins.pulse(PIN_G0 + i, 1);
      u_pins.pulse(PIN_T0 + i, 2);
      rdc(OFS_TL0 + 4'(2 * i), 8'h02, 8'hff);
    end
    // Second timer in mode 3 holds its count even with run set
    wr(OFS_MODE, 8'h30);
    wr(OFS_TL1, 8'h00);
    wr(OFS_CTRL, 8'h02);
    repeat (40) @(posedge mclk);
    rdc(OFS_TL1, 8'h00, 8'hff);
    // Second timer 16-bit counter wraps and raises its flag
    wr(OFS_MODE, 8'h50);
    wr(OFS_TH1, 8'hff);
    wr(OFS_TL1, 8'hff);
    u_pins.pulse(PIN_T1, 1);
    rdc(OFS_TH1, 8'h00, 8'hff);
    rdc(OFS_CTRL, 8'h22, 8'hff);
    // Trigger captures only once external control is enabled
    wr(OFS_CTRL, 8'h00);
    wr(OFS_TL2, 8'h34);
    wr(OFS_TH2, 8'h12);
    wr(OFS_T2CTRL, 8'h07);
    u_pins.pulse(PIN_CAPTURE_RELOAD_TRIGGER_PIN, 1);
    rdc(OFS_RCAPL, 8'h00, 8'hff);
    wr(OFS_T2CTRL, 8'h0f);
    u_pins.pulse(PIN_CAPTURE_RELOAD_TRIGGER_PIN, 1);
    rdc(OFS_RCAPL, 8'h34, 8'hff);
    rdc(OFS_RCAPH, 8'h12, 8'hff);
    chk({7'h0, timer_two_ext_flag_q}, 8'h01);
    u_pins.pulse(PIN_T2, 1);
    rdc(OFS_TL2, 8'h35, 8'hff);
    wr(OFS_T2CTRL, 8'h3c);
    u_pins.pulse(PIN_CAPTURE_RELOAD_TRIGGER_PIN, 1);
    #1;
    chk({7'h0, timer_two_ext_flag_q}, 8'h00);
    // Clock out: half period is (65536 - reload) increments
    wr(OFS_T2CTRL, 8'h00);
    wr(OFS_RCAPL, RLD[7:0]);
    wr(OFS_RCAPH, RLD[15:8]);
    wr(OFS_TL2, RLD[7:0]);
    wr(OFS_TH2, RLD[15:8]);
    wr(OFS_MISC, 8'h01);
    wr(OFS_T2MODE, 8'h02);
    wr(OFS_T2CTRL, 8'h04);
    wait_tog(hp);
    wait_tog(hp);
    chk(8'(hp), 8'(65536 - RLD));
    chk({6'h0, port_pin_oe_q, timer_two_flag_q}, 8'h02);
    @(posedge mclk);
    baud_clr <= 1'b1;
    @(posedge mclk);
    baud_clr <= 1'b0;
    wr(OFS_MISC, 8'h00);
    wr(OFS_T2CTRL, 8'h34);
    wait_tog(hp);
    wait_tog(hp);
    chk(8'(hp), 8'(2 * (65536 - RLD)));
    chk({6'h0, baud_seen, timer_two_flag_q}, 8'h02);
    // Clock-out off: pin follows the latch and drive enable
    wr(OFS_T2MODE, 8'h00);
    wr(OFS_MISC, 8'h06);
    repeat (2) @(posedge mclk);
    #1;
    chk({6'h0, port_pin_oe_q, port_pin_out_q}, 8'h03);
    results();
  end
endmodule
`default_nettype wire
